// ===== core/pir_line_router.v
// One shared PCI line: collection, polarity and destination select
`timescale 1ns/1ps
`default_nettype none
`include "pir_defs.vh"
module pir_line_router
(
  input  wire [5:0]              slot_pins_n, // Active-low slot pins
  input  wire                    extra_req,   // Onboard request, high
  input  wire [`PIR_SEL_W-1:0]   sel,         // 0 = APIC, else IRQ no.
  output wire                    line_n,      // Wired shared level
  output wire                    apic_req,    // APIC input, high
  output wire [`PIR_IRQ_W-1:0]   irq_req      // One-hot ISA request
);
  wire active;                         // Line asserted by any source
  wire legal;                          // Selected IRQ is routable
  wire [`PIR_IRQ_W-1:0] legal_map;     // One bit per routable IRQ
  assign active = (~&slot_pins_n) | extra_req;
  assign line_n = ~active;
  // Only the listed IRQs accept a redirect; others fall back to APIC
  assign legal_map = `PIR_IRQ_LEGAL;
  assign legal = legal_map[sel];
  // Redirected line leaves the APIC input idle and drives its one-hot IRQ bit high
  assign apic_req = active & ~(legal & (sel != `PIR_SEL_APIC));
  assign irq_req = (active & legal & (sel != `PIR_SEL_APIC))
                   ? (16'h0001 << sel) : 16'h0000;
endmodule // pir_line_router
`default_nettype wire

// ===== core/pir_top.v
// Top of the PCI interrupt rerouter, error SMI and register port
`timescale 1ns/1ps
`default_nettype none
`include "pir_defs.vh"
module pir_top
(
  input  wire                    sys_clk,        // 10 MHz clock
  input  wire                    rst,            // Async reset, high
  input  wire [`PIR_ADDR_W-1:0]  reg_addr,       // Register word index
  input  wire [`PIR_DATA_W-1:0]  reg_wdata,      // Write data
  input  wire                    reg_wr,         // Write strobe
  input  wire                    reg_rd,         // Read strobe
  output reg  [`PIR_DATA_W-1:0]  reg_rdata,      // Read data, next cycle
  input  wire [5:0]              pin_a_n,        // Slot pins for line A
  input  wire [5:0]              pin_b_n,        // Slot pins for line B
  input  wire [5:0]              pin_c_n,        // Slot pins for line C
  input  wire [5:0]              pin_d_n,        // Slot pins for line D
  input  wire                    usb_req,        // USB request, high
  input  wire                    scsi_req_n,     // SCSI request, low
  input  wire                    lan_req_n,      // Network request, low
  input  wire                    irq0_req,       // Legacy timer request
  input  wire                    ide_primary_req,   // Primary IDE
  input  wire                    ide_secondary_req, // Secondary IDE
  input  wire                    pci_perr_n,     // Parity error, low
  input  wire                    pci_serr_n,     // System error, low
  input  wire                    other_err,      // Other error, high
  output reg                     shared_pci_irq_line_a, // Level, low
  output reg                     shared_pci_irq_line_b, // Level, low
  output reg                     shared_pci_irq_line_c, // Level, low
  output reg                     shared_pci_irq_line_d, // Level, low
  output reg  [`PIR_IRQ_W-1:0]   pic_irq,        // PIC request lines
  output reg                     board_extra_request_1, // Secondary IDE
  output reg  [`PIR_APIC_W-1:0]  apic_in,        // APIC inputs
  output reg                     sys_mgmt_irq_n, // SMI, active low
  output reg                     irq_out         // Block interrupt
);
  // Slot order per line: P1,P2,P3,P4,S1,S2 as wired on the board
  // Route register: four 4-bit selects, line A in the low nibble
  // Path through the block, all on the one PCI-rate clock:
  //  - four line routers gather slot pins and onboard requests
  //  - each router steers its line to the APIC or to one ISA IRQ
  //  - the merged requests are registered before they leave
  //  - the error inputs fold into one management interrupt
  //  - a small register port holds steering, enables and events
  // Every output is a flop, so the controllers downstream never see
  // the glitches of the wide OR trees in front of them. The price is
  // one clock of latency on every path, which is far below what any
  // interrupt service routine can notice.

  // Software-visible registers
  reg  [`PIR_DATA_W-1:0]         route;          // Destination selects
  reg  [`PIR_CTRL_W-1:0]         ctrl;           // IRQ0 enable
  reg  [`PIR_EVT_W-1:0]          status;         // Sticky events
  reg  [`PIR_EVT_W-1:0]          mask;           // Event enables

  // Event tracking
  reg  [`PIR_EVT_W-1:0]          ev_prev;        // Last cycle levels
  wire [`PIR_EVT_W-1:0]          ev_now;         // Event levels
  wire [`PIR_EVT_W-1:0]          ev_rise;        // Event edges
  wire [`PIR_EVT_W-1:0]          next_status_w;  // Status next cycle
  wire [`PIR_EVT_W-1:0]          pending;        // Unmasked events

  // Per-line router results
  wire [3:0]                     line_n;         // Wired line levels
  wire [3:0]                     apic_pci;       // Per line APIC drive
  wire [`PIR_IRQ_W-1:0]          irq_a;          // Line A redirect
  wire [`PIR_IRQ_W-1:0]          irq_b;          // Line B redirect
  wire [`PIR_IRQ_W-1:0]          irq_c;          // Line C redirect
  wire [`PIR_IRQ_W-1:0]          irq_d;          // Line D redirect

  // Merged next values
  reg  [`PIR_IRQ_W-1:0]          next_pic_irq;   // Combined requests
  reg  [`PIR_APIC_W-1:0]         next_apic_in;   // Combined APIC
  reg  [`PIR_DATA_W-1:0]         next_reg_rdata; // Read data next cycle
  wire                           err_any;        // Any error active
  wire                           stat_rd;        // Status read now

  // Line A: USB is ORed in here, inside the bridge
  // Slot pin order in pin_a_n follows the board's rotation table
  pir_line_router u_line_a
  (
    .slot_pins_n (pin_a_n),
    .extra_req   (usb_req),
    .sel         (route[`PIR_SEL_A_LSB +: `PIR_SEL_W]),
    .line_n      (line_n[0]),
    .apic_req    (apic_pci[0]),
    .irq_req     (irq_a)
  );
  // Line B: SCSI controller shares it
  // Onboard SCSI request is low-true, so it is inverted here
  pir_line_router u_line_b
  (
    .slot_pins_n (pin_b_n),
    .extra_req   (~scsi_req_n),
    .sel         (route[`PIR_SEL_B_LSB +: `PIR_SEL_W]),
    .line_n      (line_n[1]),
    .apic_req    (apic_pci[1]),
    .irq_req     (irq_b)
  );
  // Line C: network controller shares it
  // Onboard network request is low-true, so it is inverted here
  pir_line_router u_line_c
  (
    .slot_pins_n (pin_c_n),
    .extra_req   (~lan_req_n),
    .sel         (route[`PIR_SEL_C_LSB +: `PIR_SEL_W]),
    .line_n      (line_n[2]),
    .apic_req    (apic_pci[2]),
    .irq_req     (irq_c)
  );
  // Line D: slots only
  // No onboard device shares this line, so the extra input is tied off
  pir_line_router u_line_d
  (
    .slot_pins_n (pin_d_n),
    .extra_req   (1'b0),
    .sel         (route[`PIR_SEL_D_LSB +: `PIR_SEL_W]),
    .line_n      (line_n[3]),
    .apic_req    (apic_pci[3]),
    .irq_req     (irq_d)
  );

  // Any error source that would give NMI gives SMI instead
  // Bus error pins are low-true; the other source is high-true
  assign err_any = ~pci_perr_n | ~pci_serr_n | other_err;

  // Event levels watched by the status register, one bit per source
  assign ev_now[`PIR_EVT_PERR]  = ~pci_perr_n;
  assign ev_now[`PIR_EVT_SERR]  = ~pci_serr_n;
  assign ev_now[`PIR_EVT_OTHER] = other_err;
  assign ev_now[`PIR_EVT_IDE]   = ide_primary_req;
  assign ev_now[`PIR_EVT_LINE0] = ~line_n[0];
  assign ev_now[`PIR_EVT_USB]   = usb_req;
  assign ev_rise = ev_now & ~ev_prev;
  // A status read clears it; decoded here so a new set can still win
  assign stat_rd = reg_rd & (reg_addr == `PIR_REG_STATUS);

  // Legacy request merge; redirects only ever land on the PIC side
  always @*
  begin
    next_pic_irq = irq_a | irq_b | irq_c | irq_d;
    // IRQ0 comes straight from the timer; no line may claim it
    next_pic_irq[0] = irq0_req;
    next_pic_irq[`PIR_IRQ_IDE] = next_pic_irq[`PIR_IRQ_IDE]
                                 | ide_primary_req;
  end

  // APIC inputs: PCI lines on 16-19, timer on 2 when enabled
  always @*
  begin
    next_apic_in = {`PIR_APIC_W{1'b0}};
    next_apic_in[`PIR_APIC_PCI0+3:`PIR_APIC_PCI0] = apic_pci;
    // Firmware must set the enable first, else input 2 stays low
    next_apic_in[`PIR_APIC_IRQ0] = irq0_req
                                   & ctrl[`PIR_CTRL_IRQ0];
  end

  // Shared line outputs; one cycle of latency keeps pins glitch free
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      // Idle level of an active-low wired line is high
      shared_pci_irq_line_a <= 1'b1;
      shared_pci_irq_line_b <= 1'b1;
      shared_pci_irq_line_c <= 1'b1;
      shared_pci_irq_line_d <= 1'b1;
    end
    else
    begin
      shared_pci_irq_line_a <= line_n[0];
      shared_pci_irq_line_b <= line_n[1];
      shared_pci_irq_line_c <= line_n[2];
      shared_pci_irq_line_d <= line_n[3];
    end
  end

  // Legacy request lines toward the PIC pair
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pic_irq               <= {`PIR_IRQ_W{1'b0}};
      board_extra_request_1 <= 1'b0;
    end
    else
    begin
      pic_irq               <= next_pic_irq;
      // Secondary IDE has no channel here, but the pin stays wired
      board_extra_request_1 <= ide_secondary_req;
    end
  end

  // Advanced controller inputs; idle until a line or IRQ0 asks
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      apic_in <= {`PIR_APIC_W{1'b0}};
    else
      apic_in <= next_apic_in;
  end

  // Management interrupt; a level, held while any error is active
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sys_mgmt_irq_n <= 1'b1;
    else
      sys_mgmt_irq_n <= ~err_any;
  end

  // Configuration writes: steering and IRQ0 enable are software set
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      route <= `PIR_ROUTE_RST;
      ctrl  <= {`PIR_CTRL_W{1'b0}};
      mask  <= {`PIR_EVT_W{1'b0}};
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `PIR_REG_ROUTE:
        begin
          // Upper half has no lines behind it and always reads zero
          route <= {{(`PIR_DATA_W-`PIR_ROUTE_USED){1'b0}},
                    reg_wdata[`PIR_ROUTE_USED-1:0]};
        end
        `PIR_REG_CTRL:
        begin
          ctrl <= reg_wdata[`PIR_CTRL_W-1:0];
        end
        `PIR_REG_MASK:
        begin
          mask <= reg_wdata[`PIR_EVT_W-1:0];
        end
        default:
        begin
          // Read-only or unmapped: ignored
        end
      endcase
    end
  end

  // Edge detector memory; resets to the idle level of every event
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ev_prev <= {`PIR_EVT_W{1'b0}};
    else
      ev_prev <= ev_now;
  end

  // Sticky status; a new edge wins over the read that clears
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      status <= {`PIR_EVT_W{1'b0}};
    else
      status <= next_status_w;
  end

  // Next status, shared with the interrupt flop so both move together
  assign next_status_w = stat_rd ? ev_rise : (status | ev_rise);
  // Only enabled events may raise the block interrupt
  assign pending = next_status_w & mask;

  // Interrupt output: any unmasked sticky bit
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_out <= 1'b0;
    else
      irq_out <= |pending;
  end

  // Read mux; an idle cycle returns zero so stale data never linger
  always @*
  begin
    next_reg_rdata = {`PIR_DATA_W{1'b0}};
    if (reg_rd)
    begin
      // Status clears on this same strobe, in the status process
      case (reg_addr)
        `PIR_REG_ROUTE:  next_reg_rdata = route;
        `PIR_REG_CTRL:   next_reg_rdata = {31'h0, ctrl};
        `PIR_REG_STATUS: next_reg_rdata = {26'h0, status};
        `PIR_REG_MASK:   next_reg_rdata = {26'h0, mask};
        `PIR_REG_LEVELS: next_reg_rdata = {28'h0, ~line_n};
        default:         next_reg_rdata = {`PIR_DATA_W{1'b0}};
      endcase
    end
  end

  // Read port: data appear in the cycle after the strobe only
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= {`PIR_DATA_W{1'b0}};
    else
      reg_rdata <= next_reg_rdata;
  end
endmodule // pir_top
`default_nettype wire

// ===== include/pir_defs.vh
// Constants for the PCI interrupt rerouter block
`ifndef PIR_DEFS_VH
`define PIR_DEFS_VH
`define PIR_ADDR_W      4
`define PIR_DATA_W      32
`define PIR_REG_ROUTE   4'h0
`define PIR_REG_CTRL    4'h1
`define PIR_REG_STATUS  4'h2
`define PIR_REG_MASK    4'h3
`define PIR_REG_LEVELS  4'h4
`define PIR_SEL_W       4
`define PIR_SEL_APIC    4'h0
`define PIR_SEL_A_LSB   0
`define PIR_SEL_B_LSB   4
`define PIR_SEL_C_LSB   8
`define PIR_SEL_D_LSB   12
`define PIR_ROUTE_USED  16
`define PIR_CTRL_IRQ0   0
`define PIR_CTRL_W      1
`define PIR_ROUTE_RST   32'h0000_0000
`define PIR_EVT_W       6
`define PIR_EVT_PERR    0
`define PIR_EVT_SERR    1
`define PIR_EVT_OTHER   2
`define PIR_EVT_IDE     3
`define PIR_EVT_LINE0   4
`define PIR_EVT_USB     5
`define PIR_IRQ_W       16
`define PIR_IRQ_IDE     14
`define PIR_APIC_W      24
`define PIR_APIC_IRQ0   2
`define PIR_APIC_PCI0   16
`define PIR_IRQ_LEGAL   16'hDEF8
`endif

// ===== tb/pir_ctrl_model.sv
// Far side: legacy controller pair and advanced controller inputs
`timescale 1ns/1ps
`default_nettype none
module pir_ctrl_model
(
  input  wire logic        sys_clk,   // Shared clock
  input  wire logic        rst,       // Reset, high
  input  wire logic [15:0] pic_irq,   // Lines 0-7 master, 8-15 slave
  input  wire logic [23:0] apic_in,   // Advanced controller inputs
  output logic      [15:0] pic_seen,  // Requests ever taken
  output logic      [23:0] apic_seen  // Inputs ever raised
);
  // Only remembers requests; priority and vectors lie beyond this block
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      pic_seen <= 16'h0000;
      apic_seen <= 24'h000000;
    end
    else
    begin
      pic_seen <= pic_seen | pic_irq;
      apic_seen <= apic_seen | apic_in;
    end
endmodule // pir_ctrl_model
`default_nettype wire

// ===== tb/pir_props.sv
// Checker for the PCI interrupt rerouter top ports
`timescale 1ns/1ps
`default_nettype none
`include "pir_defs.vh"
module pir_props
(
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic [5:0]             pin_d_n,
  input wire logic                   usb_req,
  input wire logic                   scsi_req_n,
  input wire logic                   lan_req_n,
  input wire logic                   irq0_req,
  input wire logic                   ide_primary_req,
  input wire logic                   pci_perr_n,
  input wire logic                   pci_serr_n,
  input wire logic                   other_err,
  input wire logic                   shared_pci_irq_line_a,
  input wire logic                   shared_pci_irq_line_b,
  input wire logic                   shared_pci_irq_line_c,
  input wire logic                   shared_pci_irq_line_d,
  input wire logic [`PIR_IRQ_W-1:0]  pic_irq,
  input wire logic [`PIR_APIC_W-1:0] apic_in,
  input wire logic                   sys_mgmt_irq_n
);
  // One domain, so one clock and one reset for all
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_smi_err;
    (!pci_perr_n || !pci_serr_n || other_err) |=> !sys_mgmt_irq_n;
  endproperty
  a_smi_err: assert property (p_smi_err) else $error("smi missing");
  property p_smi_idle;
    (pci_perr_n && pci_serr_n && !other_err) |=> sys_mgmt_irq_n;
  endproperty
  a_smi_idle: assert property (p_smi_idle) else $error("smi stray");
  property p_usb_a;
    usb_req |=> !shared_pci_irq_line_a;
  endproperty
  a_usb_a: assert property (p_usb_a) else $error("usb not on A");
  property p_scsi_b;
    !scsi_req_n |=> !shared_pci_irq_line_b;
  endproperty
  a_scsi_b: assert property (p_scsi_b) else $error("scsi not on B");
  property p_lan_c;
    !lan_req_n |=> !shared_pci_irq_line_c;
  endproperty
  a_lan_c: assert property (p_lan_c) else $error("lan not on C");
  // Line D has only slot pins, so it mirrors their AND exactly
  property p_line_d;
    1'b1 |=> (shared_pci_irq_line_d == $past(&pin_d_n));
  endproperty
  a_line_d: assert property (p_line_d) else $error("line D wrong");
  property p_ide;
    ide_primary_req |=> pic_irq[`PIR_IRQ_IDE];
  endproperty
  a_ide: assert property (p_ide) else $error("ide not on 14");
  property p_irq0;
    irq0_req |=> pic_irq[0];
  endproperty
  a_irq0: assert property (p_irq0) else $error("irq0 lost");
  property p_apic_a;
    apic_in[`PIR_APIC_PCI0] |-> !shared_pci_irq_line_a;
  endproperty
  a_apic_a: assert property (p_apic_a) else $error("apic 16 stray");
  c_smi: cover property (!sys_mgmt_irq_n);
  c_apic2: cover property (apic_in[`PIR_APIC_IRQ0]);
  c_redir: cover property (pic_irq[5] && !apic_in[`PIR_APIC_PCI0]);
endmodule // pir_props
bind pir_top pir_props u_pir_props
(
  .sys_clk(sys_clk), .rst(rst), .pin_d_n(pin_d_n), .usb_req(usb_req),
  .scsi_req_n(scsi_req_n), .lan_req_n(lan_req_n), .irq0_req(irq0_req),
  .ide_primary_req(ide_primary_req), .pci_perr_n(pci_perr_n),
  .pci_serr_n(pci_serr_n), .other_err(other_err),
  .shared_pci_irq_line_a(shared_pci_irq_line_a),
  .shared_pci_irq_line_b(shared_pci_irq_line_b),
  .shared_pci_irq_line_c(shared_pci_irq_line_c),
  .shared_pci_irq_line_d(shared_pci_irq_line_d),
  .pic_irq(pic_irq), .apic_in(apic_in), .sys_mgmt_irq_n(sys_mgmt_irq_n)
);
`default_nettype wire

// ===== tb/pir_top_tb.sv
// Self-checking bench for the PCI interrupt rerouter
`timescale 1ns/1ps
`default_nettype none
`include "pir_defs.vh"
module pir_top_tb;
  logic        sys_clk = 1'b0;         // 100 ns period
  logic        rst = 1'b1;             // Reset, high
  logic [3:0]  reg_addr = 4'h0;        // Register index
  logic [31:0] reg_wdata = 32'h0;      // Write data
  logic        reg_wr = 1'b0;          // Write strobe
  logic        reg_rd = 1'b0;          // Read strobe
  logic [5:0]  pin_n [4] = '{4{6'h3F}}; // Slot pins per line, low
  logic [5:0]  ob = 6'h00;   // usb,scsi,lan,irq0,ide1,ide2; high active
  logic [2:0]  err = 3'h0;   // perr,serr,other; high active
  wire  [31:0] rdata;        // Read data
  wire  [3:0]  line;         // Shared lines D..A
  wire  [15:0] pic;          // Legacy requests
  wire  [23:0] apic;         // Advanced inputs
  wire  [15:0] pic_seen;     // Model record
  wire  [23:0] apic_seen;    // Model record
  wire         ext1;         // Secondary IDE request
  wire         smi_n;        // Management interrupt
  wire         irq;          // Block interrupt
  int          failures = 0;
  int          tests_run = 0;
  always #50 sys_clk = ~sys_clk;
  pir_top u_pir_top
  (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .pin_a_n(pin_n[0]), .pin_b_n(pin_n[1]),
    .pin_c_n(pin_n[2]), .pin_d_n(pin_n[3]), .usb_req(ob[0]),
    .scsi_req_n(~ob[1]), .lan_req_n(~ob[2]), .irq0_req(ob[3]),
    .ide_primary_req(ob[4]), .ide_secondary_req(ob[5]),
    .pci_perr_n(~err[0]), .pci_serr_n(~err[1]), .other_err(err[2]),
    .shared_pci_irq_line_a(line[0]), .shared_pci_irq_line_b(line[1]),
    .shared_pci_irq_line_c(line[2]), .shared_pci_irq_line_d(line[3]),
    .pic_irq(pic), .board_extra_request_1(ext1), .apic_in(apic),
    .sys_mgmt_irq_n(smi_n), .irq_out(irq)
  );
  pir_ctrl_model u_pir_ctrl_model
  (
    .sys_clk(sys_clk), .rst(rst), .pic_irq(pic), .apic_in(apic),
    .pic_seen(pic_seen), .apic_seen(apic_seen)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe, so sample then
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Pull one line's pins to v, others idle; outputs lag one clock
  task automatic pins(input int l, input logic [5:0] v);
    @(posedge sys_clk);
    for (int k = 0; k < 4; k++)
      pin_n[k] <= (k == l) ? v : 6'h3F;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic srcs(input logic [5:0] o, input logic [2:0] e);
    @(posedge sys_clk);
    ob <= o;
    err <= e;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic t_slots;
    logic [31:0] d;
    for (int l = 0; l < 4; l++)
      for (int p = 0; p < 6; p++)
      begin
        pins(l, ~(6'h01 << p));
        chk(line, 4'hF ^ (4'h1 << l));
        chk(apic[19:16], 4'h1 << l);
      end
    rd(`PIR_REG_LEVELS, d);
    chk(d, 32'h8);
    pins(4, 6'h3F);
    for (int k = 0; k < 3; k++)
    begin
      srcs(6'h01 << k, 3'h0);
      chk(line, 4'hF ^ (4'h1 << k));
    end
  endtask
  // Selector codes 1-15: legal ones redirect, the rest stay on APIC
  task automatic t_route;
    logic [31:0] d;
    bit          ok;
    srcs(6'h00, 3'h0);
    for (int s = 1; s < 16; s++)
    begin
      ok = |((`PIR_IRQ_LEGAL >> s) & 1);
      wr(`PIR_REG_ROUTE, s << (4 * (s % 4)));
      pins(s % 4, 6'h3E);
      chk(pic, ok ? 16'h1 << s : 16'h0);
      chk(apic[19:16], ok ? 4'h0 : 4'h1 << (s % 4));
      rd(`PIR_REG_ROUTE, d);
      chk(d, s << (4 * (s % 4)));
    end
    wr(`PIR_REG_ROUTE, 32'h0);
    pins(4, 6'h3F);
  endtask
  task automatic t_irq0;
    srcs(6'h08, 3'h0);
    chk({pic[0], apic[2]}, 2'b10);
    wr(`PIR_REG_CTRL, 32'h1);
    @(posedge sys_clk);
    #1 chk(apic[2], 1'b1);
    wr(`PIR_REG_CTRL, 32'h0);
    srcs(6'h38, 3'h0);
    chk({pic[14], ext1, apic[2]}, 3'b110);
  endtask
  // Each error lowers the management line and raises an enabled event
  task automatic t_err;
    logic [31:0] d;
    srcs(6'h00, 3'h0);
    rd(`PIR_REG_STATUS, d);
    chk(d, 32'h38);
    wr(`PIR_REG_MASK, 32'h7);
    for (int k = 0; k < 3; k++)
    begin
      srcs(6'h00, 3'h1 << k);
      chk({smi_n, irq}, 2'b01);
      rd(`PIR_REG_STATUS, d);
      chk(d, 32'h1 << k);
      srcs(6'h00, 3'h0);
      chk({smi_n, irq}, 2'b10);
    end
    wr(`PIR_REG_MASK, 32'h0);
    srcs(6'h00, 3'h2);
    chk({smi_n, irq}, 2'b00);
    rd(4'hF, d);
    chk(d, 32'h0);
    chk(pic_seen, 16'hDEF9);
    chk(apic_seen, 24'h0F0004);
  endtask
  task automatic finish_test;
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #1_000_000;
    failures++;
    finish_test;
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_slots;
    t_route;
    t_irq0;
    t_err;
    finish_test;
  end
endmodule // pir_top_tb
`default_nettype wire
